// File: logic/lcsi_top.sv
// Light curtain receiver status indicator with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module lcsi_top #(
    parameter lcsi_pkg::lcsi_cnt_t SLOW_HALF = lcsi_pkg::SLOW_HALF_CYCLES,
    parameter lcsi_pkg::lcsi_cnt_t FAST_HALF = lcsi_pkg::FAST_HALF_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Receiver conditions, asynchronous levels
    input  wire logic        field_interrupted,
    input  wire logic        beams_misaligned,
    input  wire logic        external_fault,
    input  wire logic        internal_fault,
    input  wire logic        weak_signal,
    input  wire logic        interlock_locked,
    input  wire logic        control_circuit_open,
    input  wire logic        startup_active,
    input  wire logic        tx_on_channel_two,
    input  wire logic [7:0]  fault_number,
    // Indicators
    output logic             primary_status_lamp_red,
    output logic             primary_status_lamp_green,
    output logic             interlock_status_lamp_yellow,
    output logic             switching_output_lamp_red,
    output logic [6:0]       seg_left,
    output logic [6:0]       seg_mid,
    output logic [6:0]       seg_right,
    output logic             irq
);
    import lcsi_pkg::*;

    localparam int unsigned SYNC_W = COND_W + 8;

    // Two-stage synchroniser for every condition pin
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {fault_number, tx_on_channel_two, startup_active, control_circuit_open,
                        interlock_locked, weak_signal, internal_fault, external_fault,
                        beams_misaligned, field_interrupted};
            sync2_q <= sync1_q;
        end
    end

    logic       fld_s, mis_s, ext_s, int_s, weak_s, lock_s, open_s, start_s, ch2_s;
    logic [7:0] num_s;
    assign {num_s, ch2_s, start_s, open_s, lock_s, weak_s, int_s, ext_s, mis_s, fld_s} = sync2_q;

    // Flash generators
    lcsi_flash_if slow_if ();
    lcsi_flash_if fast_if ();
    lcsi_flash #(.HALF_CYCLES(SLOW_HALF)) u_slow (
        .aclk    (aclk),
        .aresetn (aresetn),
        .flash   (slow_if)
    );
    lcsi_flash #(.HALF_CYCLES(FAST_HALF)) u_fast (
        .aclk    (aclk),
        .aresetn (aresetn),
        .flash   (fast_if)
    );

    // Software-held operating mode
    logic [CTRL_MODE_W-1:0] mode_q;
    logic [IRQ_W-1:0]       irq_stat_q;
    logic [IRQ_W-1:0]       irq_mask_q;

    lcsi_pat_t pat;
    always_comb begin
        if (int_s) begin
            pat = LCSI_PAT_INT;
        end else if (ext_s) begin
            pat = LCSI_PAT_EXT;
        end else if (fld_s || mis_s) begin
            pat = LCSI_PAT_RED;
        end else if (weak_s) begin
            pat = LCSI_PAT_WEAK;
        end else begin
            pat = LCSI_PAT_OK;
        end
    end

    // Primary lamp drive, registered to keep glitches off the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primary_status_lamp_red   <= 1'b0;
            primary_status_lamp_green <= 1'b0;
        end else begin
            unique case (pat)
                LCSI_PAT_INT: begin
                    primary_status_lamp_red   <= fast_if.phase;
                    primary_status_lamp_green <= 1'b0;
                end
                LCSI_PAT_EXT: begin
                    primary_status_lamp_red   <= slow_if.phase;
                    primary_status_lamp_green <= 1'b0;
                end
                LCSI_PAT_RED: begin
                    primary_status_lamp_red   <= 1'b1;
                    primary_status_lamp_green <= 1'b0;
                end
                LCSI_PAT_WEAK: begin
                    primary_status_lamp_red   <= 1'b0;
                    primary_status_lamp_green <= slow_if.phase;
                end
                LCSI_PAT_OK: begin
                    primary_status_lamp_red   <= 1'b0;
                    primary_status_lamp_green <= 1'b1;
                end
                default: begin
                    primary_status_lamp_red   <= 1'b1;
                    primary_status_lamp_green <= 1'b0;
                end
            endcase
        end
    end

    // Interlock lamp; outside mode CTRL_MODE_RST an open circuit outranks the ready indication
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interlock_status_lamp_yellow <= 1'b0;
        end else if (open_s && (mode_q != CTRL_MODE_RST)) begin
            interlock_status_lamp_yellow <= slow_if.phase;
        end else begin
            interlock_status_lamp_yellow <= lock_s && !fld_s;
        end
    end

    // Switching-output lamp
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            switching_output_lamp_red <= 1'b0;
        end else begin
            switching_output_lamp_red <= fld_s;
        end
    end

    // Fault number digits; above 99 wraps modulo 100
    logic [7:0] num_mod;
    logic [7:0] num_tens;
    logic [7:0] num_units;
    assign num_mod   = num_s % DEC_HUNDRED;
    assign num_tens  = num_mod / DEC_TEN;
    assign num_units = num_mod % DEC_TEN;

    // Seven-segment display content
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seg_left  <= SEG_BLANK;
            seg_mid   <= SEG_BLANK;
            seg_right <= SEG_BLANK;
        end else if (int_s || ext_s) begin
            seg_left  <= int_s ? SEG_F : SEG_E;
            seg_mid   <= SEG_DIGIT[num_tens[3:0]];
            seg_right <= SEG_DIGIT[num_units[3:0]];
        end else if (start_s) begin
            seg_left  <= SEG_C;
            seg_mid   <= ch2_s ? SEG_DIGIT[CHAN_TWO] : SEG_DIGIT[CHAN_ONE];
            seg_right <= SEG_BLANK;
        end else begin
            seg_left  <= SEG_BLANK;
            seg_mid   <= SEG_BLANK;
            seg_right <= SEG_BLANK;
        end
    end

    // Rising-edge events for the interrupt status
    logic [IRQ_W-1:0] ev_lvl;
    logic [IRQ_W-1:0] ev_prev_q;
    logic [IRQ_W-1:0] ev_rise;
    assign ev_lvl = {open_s && (mode_q != CTRL_MODE_RST), weak_s, fld_s || mis_s, ext_s, int_s};
    assign ev_rise = ev_lvl & ~ev_prev_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_prev_q <= IRQ_RST;
        end else begin
            ev_prev_q <= ev_lvl;
        end
    end

    // AXI write channel capture; address and data may come in either order
    logic        aw_have_q;
    logic [7:0]  aw_addr_q;
    logic        w_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic [31:0] wr_bits;
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_bits       = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[ADDR_MSB:ADDR_LSB], 2'b00};
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            w_data_q <= DATA_ZERO;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    // Write response; unmapped and read-only addresses answer SLVERR
    logic wr_hit;
    assign wr_hit = (aw_addr_q == OFS_CTRL) || (aw_addr_q == OFS_IRQ_STAT) || (aw_addr_q == OFS_IRQ_MASK);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register, byte lane 0 holds the mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= CTRL_MODE_RST;
        end else if (wr_fire && (aw_addr_q == OFS_CTRL) && w_strb_q[0]) begin
            mode_q <= w_data_q[CTRL_MODE_LSB +: CTRL_MODE_W];
        end
    end

    // Interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q <= IRQ_RST;
        end else if (wr_fire && (aw_addr_q == OFS_IRQ_MASK)) begin
            irq_mask_q <= (irq_mask_q & ~wr_bits[IRQ_W-1:0]) | (w_data_q[IRQ_W-1:0] & wr_bits[IRQ_W-1:0]);
        end
    end

    // Sticky status, write one to clear; a new event wins over its clear
    logic [IRQ_W-1:0] irq_clr;
    assign irq_clr = (wr_fire && (aw_addr_q == OFS_IRQ_STAT)) ? (w_data_q[IRQ_W-1:0] & wr_bits[IRQ_W-1:0]) : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= IRQ_RST;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | ev_rise;
        end
    end

    // Level interrupt, registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read path: one outstanding read, data one cycle after the address
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_hit;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_addr = {s_axi_araddr[ADDR_MSB:ADDR_LSB], 2'b00};
    always_comb begin
        rd_data = DATA_ZERO;
        rd_hit  = 1'b1;
        unique case (rd_addr)
            OFS_CTRL:     rd_data[CTRL_MODE_W-1:0] = mode_q;
            OFS_LAMP: begin
                rd_data[LAMP_W-1:0] = {switching_output_lamp_red, interlock_status_lamp_yellow,
                                       primary_status_lamp_green, primary_status_lamp_red};
                rd_data[COND_LSB +: COND_W] = sync2_q[COND_W-1:0];
            end
            OFS_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat_q;
            OFS_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_q;
            OFS_FAULT: begin
                rd_data[7:0]          = num_s;
                rd_data[FAULT_CLS_BIT] = ext_s && !int_s;
            end
            default:      rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= DATA_ZERO;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : lcsi_top
`default_nettype wire

// File: logic/lcsi_pkg.sv
// Constants shared by the light curtain status indicator block
package lcsi_pkg;
    // Clock and flash timing
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned SLOW_PERIOD_MS = 1000;
    localparam int unsigned FAST_PERIOD_MS = 100;
    localparam int unsigned FLASH_CNT_W    = 24;
    typedef logic [FLASH_CNT_W-1:0] lcsi_cnt_t;
    localparam lcsi_cnt_t SLOW_HALF_CYCLES = lcsi_cnt_t'(CLK_HZ / 1000 * SLOW_PERIOD_MS / 2);
    localparam lcsi_cnt_t FAST_HALF_CYCLES = lcsi_cnt_t'(CLK_HZ / 1000 * FAST_PERIOD_MS / 2);

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_LAMP      = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h0c;
    localparam logic [7:0] OFS_FAULT     = 8'h10;
    localparam int unsigned ADDR_LSB     = 2;
    localparam int unsigned ADDR_MSB     = 7;

    // Field layouts
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_MODE_W   = 2;
    localparam int unsigned IRQ_W         = 5;
    localparam int unsigned IRQ_INT       = 0;
    localparam int unsigned IRQ_EXT       = 1;
    localparam int unsigned IRQ_FIELD     = 2;
    localparam int unsigned IRQ_WEAK      = 3;
    localparam int unsigned IRQ_OPEN      = 4;
    localparam int unsigned LAMP_W        = 4;
    localparam int unsigned COND_LSB      = 8;
    localparam int unsigned COND_W        = 9;
    localparam int unsigned FAULT_CLS_BIT = 8;

    // Reset values
    localparam logic [CTRL_MODE_W-1:0] CTRL_MODE_RST = 2'h0;
    localparam logic [IRQ_W-1:0]       IRQ_RST       = 5'h00;
    localparam logic [31:0]            DATA_ZERO     = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decimal split of fault numbers
    localparam logic [7:0] DEC_TEN     = 8'h0a;
    localparam logic [7:0] DEC_HUNDRED = 8'h64;

    // Seven-segment patterns, gfedcba active high
    typedef logic [6:0] lcsi_seg_t;
    localparam lcsi_seg_t SEG_BLANK = 7'h00;
    localparam lcsi_seg_t SEG_C     = 7'h39;
    localparam lcsi_seg_t SEG_E     = 7'h79;
    localparam lcsi_seg_t SEG_F     = 7'h71;
    localparam lcsi_seg_t SEG_DIGIT [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                                            7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    localparam int unsigned CHAN_ONE = 1;
    localparam int unsigned CHAN_TWO = 2;

    // Primary lamp patterns, in falling priority
    typedef enum logic [2:0] {
        LCSI_PAT_INT  = 3'b000,
        LCSI_PAT_EXT  = 3'b001,
        LCSI_PAT_RED  = 3'b010,
        LCSI_PAT_WEAK = 3'b011,
        LCSI_PAT_OK   = 3'b100
    } lcsi_pat_t;
endpackage : lcsi_pkg

// File: logic/lcsi_flash_if.sv
// Flash phase carried from a flash generator to the indicator logic
`timescale 1ns/10ps
`default_nettype none
interface lcsi_flash_if;
    logic phase;
    modport gen (output phase);
    modport use_side (input phase);
endinterface : lcsi_flash_if
`default_nettype wire

// File: logic/lcsi_flash.sv
// Square-wave flash generator with a programmable half period
`timescale 1ns/10ps
`default_nettype none
module lcsi_flash #(
    parameter lcsi_pkg::lcsi_cnt_t HALF_CYCLES = lcsi_pkg::SLOW_HALF_CYCLES
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    lcsi_flash_if.gen flash
);
    import lcsi_pkg::*;

    lcsi_cnt_t cnt_q;
    logic      phase_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q   <= '0;
            phase_q <= 1'b0;
        end else if (cnt_q == HALF_CYCLES - lcsi_cnt_t'(1)) begin
            cnt_q   <= '0;
            phase_q <= ~phase_q;
        end else begin
            cnt_q <= cnt_q + lcsi_cnt_t'(1);
        end
    end

    assign flash.phase = phase_q;
endmodule : lcsi_flash
`default_nettype wire

// File: verif/lcsi_props.sv
// Assertions on the indicator pins
`timescale 1ns/10ps
`default_nettype none
module lcsi_props #(
    parameter lcsi_pkg::lcsi_cnt_t SLOW_HALF = lcsi_pkg::SLOW_HALF_CYCLES,
    parameter lcsi_pkg::lcsi_cnt_t FAST_HALF = lcsi_pkg::FAST_HALF_CYCLES
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       field_interrupted,
    input wire logic       beams_misaligned,
    input wire logic       external_fault,
    input wire logic       internal_fault,
    input wire logic       weak_signal,
    input wire logic       interlock_locked,
    input wire logic       control_circuit_open,
    input wire logic       primary_status_lamp_red,
    input wire logic       primary_status_lamp_green,
    input wire logic       interlock_status_lamp_yellow,
    input wire logic       switching_output_lamp_red,
    input wire logic [6:0] seg_left,
    input wire logic       irq
);
    import lcsi_pkg::*;
    logic [2:0] up_q;
    logic       red_q;
    logic       live;
    lcsi_cnt_t  run_q;
    lcsi_cnt_t  ifc_q;
    logic [6:0] c_now, d1_q, d2_q, d3_q, d4_q, on, off;

    // Pins take three edges to lamps; on/off needs two equal samples
    assign c_now = {control_circuit_open, interlock_locked, weak_signal, internal_fault,
                    external_fault, beams_misaligned, field_interrupted};
    assign on    = d3_q & d4_q;
    assign off   = ~(d3_q | d4_q);
    assign live  = up_q == 3'h7;

    // Delay line, settle count, red run, fault age
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_q  <= 3'h0;
            ifc_q <= '0;
        end else begin
            up_q  <= live ? up_q : up_q + 3'h1;
            ifc_q <= !internal_fault ? '0 : ((&ifc_q) ? ifc_q : ifc_q + 1'b1);
        end
        {d4_q, d3_q, d2_q, d1_q} <= {d3_q, d2_q, d1_q, c_now};
        red_q <= primary_status_lamp_red;
        run_q <= (primary_status_lamp_red != red_q) ? lcsi_cnt_t'(1) : run_q + 1'b1;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_green_steady: assert property (live && off[4:0] == 5'h1f |-> primary_status_lamp_green && !primary_status_lamp_red)
        else $error("green lamp not steady");
    a_red_steady: assert property (live && (on[0] || on[1]) && off[3] && off[2] |-> primary_status_lamp_red && !primary_status_lamp_green)
        else $error("red lamp not steady");
    a_output_red: assert property (live && (on[0] || off[0]) |-> switching_output_lamp_red == on[0])
        else $error("output lamp wrong");
    a_int_code: assert property (live && on[3] |-> seg_left == SEG_F && !primary_status_lamp_green)
        else $error("internal code wrong");
    a_ext_code: assert property (live && on[2] && off[3] |-> seg_left == SEG_E && !primary_status_lamp_green)
        else $error("external code wrong");
    a_weak_nored: assert property (live && on[4] && off[3:0] == 4'hf |-> !primary_status_lamp_red)
        else $error("weak signal shows red");
    a_lock_steady: assert property (live && on[5] && off[0] && off[6] |-> interlock_status_lamp_yellow)
        else $error("interlock lamp dark");
    a_lock_blocked: assert property (live && on[0] && off[6] |-> !interlock_status_lamp_yellow)
        else $error("interlock lamp lit in field");
    a_fast_half: assert property (live && primary_status_lamp_red != red_q && ifc_q > 2 * FAST_HALF + 8 |-> run_q == FAST_HALF)
        else $error("fast flash half period wrong");

    c_fast: cover property (live && on[3] && primary_status_lamp_red != red_q);
    c_lock: cover property (live && on[6] && interlock_status_lamp_yellow);
    c_irq: cover property (irq);
endmodule : lcsi_props
`default_nettype wire

// File: verif/lcsi_viewer.sv
// Operator view: counts changes of the red, green and yellow lamps
`timescale 1ns/10ps
`default_nettype none
module lcsi_viewer (
    input  wire logic  aclk,
    input  wire logic  clr,
    input  wire logic  red,
    input  wire logic  green,
    input  wire logic  yellow,
    output int unsigned red_flips,
    output int unsigned grn_flips,
    output int unsigned yel_flips
);
    logic [2:0] last_q;
    // A flash shows as a stream of changes, a steady lamp as none
    always_ff @(posedge aclk) begin
        last_q <= {yellow, green, red};
        if (clr) begin
            red_flips <= 0;
            grn_flips <= 0;
            yel_flips <= 0;
        end else begin
            red_flips <= red_flips + 32'(red != last_q[0]);
            grn_flips <= grn_flips + 32'(green != last_q[1]);
            yel_flips <= yel_flips + 32'(yellow != last_q[2]);
        end
    end
endmodule : lcsi_viewer
`default_nettype wire

// File: verif/tb.sv
// Bench for lamps, display, registers and interrupt
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; $display("BAD %s exp %0h got %0h", n, e, a); end end
module tb;
    import lcsi_pkg::*;
    localparam int SH = 10;
    localparam int FH = 2;
    logic        aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [8:0]  cond = '0;
    logic [7:0]  fault_number = '0;
    logic        primary_status_lamp_red, primary_status_lamp_green, interlock_status_lamp_yellow;
    logic        switching_output_lamp_red, irq;
    lcsi_seg_t   seg_left, seg_mid, seg_right;
    int unsigned rf, gf, yf, red_flips, grn_flips, yel_flips;
    int          n_errors = 0, checked = 0;

    lcsi_top #(.SLOW_HALF(lcsi_cnt_t'(SH)), .FAST_HALF(lcsi_cnt_t'(FH))) DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .field_interrupted(cond[0]), .beams_misaligned(cond[1]), .external_fault(cond[2]),
        .internal_fault(cond[3]), .weak_signal(cond[4]), .interlock_locked(cond[5]),
        .control_circuit_open(cond[6]), .startup_active(cond[7]), .tx_on_channel_two(cond[8]),
        .fault_number, .primary_status_lamp_red, .primary_status_lamp_green, .interlock_status_lamp_yellow,
        .switching_output_lamp_red, .seg_left, .seg_mid, .seg_right, .irq);
    lcsi_viewer u_view (.aclk, .clr, .red(primary_status_lamp_red), .green(primary_status_lamp_green),
        .yellow(interlock_status_lamp_yellow), .red_flips, .grn_flips, .yel_flips);

    // 25 MHz clock
    initial begin
        forever #20 aclk = ~aclk;
    end

    task wrap_up;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // One AXI4-Lite transfer; handshakes sampled before each edge
    task axi(input logic wr, input logic [31:0] a, d, ed, input logic [1:0] er);
        int i;
        logic ta, tw, tk;
        if (wr) begin
            s_axi_awaddr  <= a;
            s_axi_wdata   <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid  <= 1'b1;
            s_axi_bready  <= 1'b1;
        end else begin
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready  <= 1'b1;
        end
        for (i = 0; i < 64; i++) begin
            @(negedge aclk);
            ta = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
            tw = s_axi_wvalid && s_axi_wready;
            tk = wr ? s_axi_bvalid : s_axi_rvalid;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge aclk);
            if (ta && wr) s_axi_awvalid <= 1'b0;
            if (ta && !wr) s_axi_arvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tk) break;
        end
        if (i == 64) begin
            n_errors++;
            $display("BAD handshake exp 1 got 0");
            wrap_up();
        end
        `CHK("resp", er, rs)
        if (!wr) `CHK("rdata", ed, rd)
    endtask : axi

    // Pins reach the lamps three edges after a change
    task set_in(input logic [8:0] c, input logic [7:0] n);
        cond         <= c;
        fault_number <= n;
        repeat (6) @(posedge aclk);
    endtask : set_in

    task pins(input string s, input logic [3:0] mk, input logic [3:0] e, input lcsi_seg_t l, m, r);
        @(negedge aclk);
        `CHK(s, e, mk & {switching_output_lamp_red, interlock_status_lamp_yellow,
                         primary_status_lamp_green, primary_status_lamp_red})
        `CHK(s, {l, m, r}, {seg_left, seg_mid, seg_right})
        `CHK("irq", 1'b0, irq)
        @(posedge aclk);
    endtask : pins

    // Lamp changes over 40 cycles, whole half periods
    task watch;
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (40) @(posedge aclk);
        @(negedge aclk);
        rf = red_flips;
        gf = grn_flips;
        yf = yel_flips;
        @(posedge aclk);
    endtask : watch

    task irq_is(input logic e);
        @(negedge aclk);
        `CHK("irq", e, irq)
        @(posedge aclk);
    endtask : irq_is

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi(1'b0, 32'(OFS_CTRL), DATA_ZERO, DATA_ZERO, RESP_OKAY);
        axi(1'b0, 32'(OFS_IRQ_MASK), DATA_ZERO, DATA_ZERO, RESP_OKAY);
        axi(1'b0, 32'h0000_0020, DATA_ZERO, DATA_ZERO, RESP_SLVERR);
        axi(1'b1, 32'(OFS_LAMP), 32'h0000_000f, DATA_ZERO, RESP_SLVERR);
        $display("test registers done");
        set_in(9'h000, 8'h00);
        pins("clear", 4'hf, 4'h2, SEG_BLANK, SEG_BLANK, SEG_BLANK);
        set_in(9'h020, 8'h00);
        pins("locked", 4'hf, 4'h6, SEG_BLANK, SEG_BLANK, SEG_BLANK);
        set_in(9'h021, 8'h00);
        pins("interrupted", 4'hf, 4'h9, SEG_BLANK, SEG_BLANK, SEG_BLANK);
        set_in(9'h002, 8'h00);
        pins("misaligned", 4'hf, 4'h1, SEG_BLANK, SEG_BLANK, SEG_BLANK);
        for (int c = 0; c < 2; c++) begin
            set_in({c[0], 8'h80}, 8'h00);
            pins("startup", 4'hf, 4'h2, SEG_C, SEG_DIGIT[CHAN_ONE + c], SEG_BLANK);
        end
        $display("test steady done");
        set_in(9'h004, 8'h07);
        pins("external", 4'he, 4'h0, SEG_E, SEG_DIGIT[0], SEG_DIGIT[7]);
        watch();
        `CHK("slow red", 32'(40 / SH), rf)
        axi(1'b0, 32'(OFS_FAULT), DATA_ZERO, 32'h0000_0107, RESP_OKAY);
        set_in(9'h00c, 8'd123);
        pins("internal", 4'he, 4'h0, SEG_F, SEG_DIGIT[2], SEG_DIGIT[3]);
        watch();
        `CHK("fast red", 32'(40 / FH), rf)
        axi(1'b0, 32'(OFS_FAULT), DATA_ZERO, 32'h0000_007b, RESP_OKAY);
        set_in(9'h010, 8'h00);
        watch();
        `CHK("slow green", 32'(40 / SH), gf)
        `CHK("no red", 32'd0, rf)
        set_in(9'h011, 8'h00);
        watch();
        `CHK("steady red", 32'd0, rf)
        $display("test flash done");
        for (int m = 0; m < 4; m++) begin
            axi(1'b1, 32'(OFS_CTRL), 32'(m), DATA_ZERO, RESP_OKAY);
            axi(1'b0, 32'(OFS_CTRL), DATA_ZERO, 32'(m), RESP_OKAY);
            set_in(9'h060, 8'h00);
            watch();
            `CHK("yellow flips", (m == 0) ? 32'd0 : 32'(40 / SH), yf)
        end
        $display("test interlock done");
        set_in(9'h000, 8'h00);
        axi(1'b1, 32'(OFS_IRQ_STAT), 32'h0000_001f, DATA_ZERO, RESP_OKAY);
        axi(1'b1, 32'(OFS_IRQ_MASK), 32'h0000_0002, DATA_ZERO, RESP_OKAY);
        irq_is(1'b0);
        set_in(9'h001, 8'h00);
        irq_is(1'b0);
        set_in(9'h005, 8'h01);
        irq_is(1'b1);
        axi(1'b0, 32'(OFS_IRQ_STAT), DATA_ZERO, 32'h0000_0006, RESP_OKAY);
        axi(1'b1, 32'(OFS_IRQ_STAT), 32'h0000_0002, DATA_ZERO, RESP_OKAY);
        irq_is(1'b0);
        axi(1'b0, 32'(OFS_IRQ_STAT), DATA_ZERO, 32'h0000_0004, RESP_OKAY);
        $display("test interrupt done");
        wrap_up();
    end
endmodule : tb

bind lcsi_top lcsi_props #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) u_props (
    .aclk, .aresetn, .field_interrupted, .beams_misaligned, .external_fault, .internal_fault,
    .weak_signal, .interlock_locked, .control_circuit_open, .primary_status_lamp_red,
    .primary_status_lamp_green, .interlock_status_lamp_yellow, .switching_output_lamp_red, .seg_left, .irq);
`default_nettype wire
